/* File: verilog/ssm_select_mode.sv */
/*
  Select handling, master/slave role logic and byte shifter of the serial
  controller. Register bits are plain ports; software write and read
  strobes are one-cycle pulses. Pin inputs are synchronous to core_clk.
*/
// Operation
// - Slave role: select pin always input
// - Select low: active, MISO drives if configured
// - Select high: all inputs, ignore clock, data
// - Select rising: reset bit counter, shifter kept
// - Master role: select direction left to software
// - Select low in master input: demote to slave
// - Demotion sets done flag, interrupt if enabled
// - Low rate bit: serial clock is core/16
// - Master write transmits, then done flag set
// - Slave: data read returns received byte
// - Master write starts clock, eight bits, stops
// - Single transmit buffer, double receive buffer
`timescale 1ns/1ps
module ssm_select_mode
  import ssm_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         serialUnitEnable,
  input  wire logic         roleSetMaster,    // Software sets role bit
  input  wire logic         roleClear,        // Software clears role bit
  input  wire logic         rateSelectLow,
  input  wire logic         transferIrqEnable,
  input  wire logic         globalIrqEnable,
  input  ssm_pin_dir_t      pinDir,
  input  wire logic         dataWrite,
  input  wire logic [7:0]   dataWriteValue,
  input  wire logic         dataRead,
  input  wire logic         statusRead,
  input  wire logic         irqAck,
  input  wire logic         selIn,
  input  wire logic         sckIn,
  input  wire logic         mosiIn,
  input  wire logic         misoIn,
  output logic              controllerRoleBit,
  output logic              transferDoneFlag,
  output logic              transferIrq,
  output logic [7:0]        serialDataRead,
  output logic              sckOut,
  output logic              mosiOut,
  output logic              misoOut,
  output ssm_pin_oe_t       pinOeN
);

  // Shared shift state
  logic [7:0]     shift_q, shift_d;      // Shift register
  logic [3:0]     bitCnt_q, bitCnt_d;    // Bits shifted so far
  logic [3:0]     div_q, div_d;          // Serial clock divider
  ssm_mst_state_t mst_q, mst_d;          // Master sequencer
  logic           sckPrev_q;             // Last sampled slave clock
  logic           selPrev_q;             // Last sampled select
  logic           armed_q;               // Status read seen with flag set
  logic           byteDone;              // Byte finished this cycle
  logic [7:0]     rxByte;                // Byte handed to the buffer

  // Role and select decode
  wire isMaster    = serialUnitEnable & controllerRoleBit;
  wire isSlave     = serialUnitEnable & ~controllerRoleBit;
  // Select is forced input in slave role, whatever pinDir says
  wire selIsInput  = isSlave | ~pinDir.selDir;
  wire modeFault   = isMaster & ~pinDir.selDir & ~selIn;
  wire slaveActive = isSlave & ~selIn;
  wire selRise     = isSlave & selIn & ~selPrev_q;
  // Only the falling slave clock matters: data is taken and shifted there
  wire sckFall     = slaveActive & ~sckIn & sckPrev_q;
  wire [3:0] halfDiv = rateSelectLow ? 4'(HALF_SLOW - 1) : 4'(HALF_FAST - 1);
  wire divTick     = (div_q == halfDiv);
  // Single transmit buffer: writes load the shifter directly when idle
  wire mstStart    = isMaster & dataWrite & (mst_q == MST_IDLE);
  wire slvLoad     = isSlave & dataWrite & (bitCnt_q == CNT_RESET);
  wire flagClear   = irqAck | (armed_q & (dataRead | dataWrite));

  // Master sequencer: low half, then high half; sample and shift on fall
  always_comb begin
    mst_d    = mst_q;
    div_d    = div_q;
    shift_d  = shift_q;
    bitCnt_d = bitCnt_q;
    byteDone = 1'b0;
    rxByte   = shift_q;
    if (!serialUnitEnable || modeFault) begin
      // Demotion abandons the master byte
      mst_d    = MST_IDLE;
      div_d    = CNT_RESET;
      bitCnt_d = CNT_RESET;
    end else if (isMaster) begin
      unique case (mst_q)
        MST_IDLE: begin
          if (mstStart) begin
            shift_d  = dataWriteValue;
            bitCnt_d = CNT_RESET;
            div_d    = CNT_RESET;
            mst_d    = MST_LOW;
          end
        end
        MST_LOW: begin
          div_d = divTick ? CNT_RESET : div_q + 4'h1;
          if (divTick) begin
            // Rising serial clock: data already stands on the pin
            mst_d = MST_HIGH;
          end
        end
        MST_HIGH: begin
          div_d = divTick ? CNT_RESET : div_q + 4'h1;
          if (divTick) begin
            shift_d  = {shift_q[6:0], misoIn};
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == 4'(BITS_PER_BYTE - 1)) begin
              // Eighth bit: stop clock and report
              byteDone = 1'b1;
              rxByte   = {shift_q[6:0], misoIn};
              bitCnt_d = CNT_RESET;
              mst_d    = MST_IDLE;
            end else begin
              mst_d = MST_LOW;
            end
          end
        end
        default: mst_d = MST_IDLE;
      endcase
    end else begin
      // Slave role
      mst_d = MST_IDLE;
      if (selRise) begin
        // Drop partial byte at once
        bitCnt_d = CNT_RESET;
      end else if (slvLoad) begin
        shift_d = dataWriteValue;
      end else if (sckFall) begin
        // Passive while select high: edges only count when active
        shift_d  = {shift_q[6:0], mosiIn};
        bitCnt_d = bitCnt_q + 4'h1;
        if (bitCnt_q == 4'(BITS_PER_BYTE - 1)) begin
          byteDone = 1'b1;
          rxByte   = {shift_q[6:0], mosiIn};
          bitCnt_d = CNT_RESET;
        end
      end
    end
  end

  // Received byte goes to its own buffer
  ssm_rx_buffer u_rxBuf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (byteDone),
    .loadData (rxByte),
    .readData (serialDataRead)
  );

  // Sequencer and shift registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mst_q     <= MST_IDLE;
      div_q     <= CNT_RESET;
      shift_q   <= DATA_RESET;
      bitCnt_q  <= CNT_RESET;
      sckPrev_q <= 1'b0;
      selPrev_q <= 1'b1;
    end else begin
      mst_q     <= mst_d;
      div_q     <= div_d;
      shift_q   <= shift_d;
      bitCnt_q  <= bitCnt_d;
      sckPrev_q <= sckIn;
      selPrev_q <= selIn;
    end
  end

  // Role bit: fault clear wins over a software set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      controllerRoleBit <= 1'b0;
    end else if (modeFault || roleClear) begin
      controllerRoleBit <= 1'b0;
    end else if (roleSetMaster) begin
      // Only software brings master role back
      controllerRoleBit <= 1'b1;
    end
  end

  // Done flag: set beats clear so no event is lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      transferDoneFlag <= 1'b0;
      armed_q          <= 1'b0;
    end else begin
      if (byteDone || modeFault) begin
        transferDoneFlag <= 1'b1;
      end else if (flagClear) begin
        transferDoneFlag <= 1'b0;
      end
      // Arm the read-then-access clear sequence
      if (flagClear || byteDone || modeFault) begin
        armed_q <= 1'b0;
      end else if (statusRead && transferDoneFlag) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Interrupt request gated by both enables
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      transferIrq <= 1'b0;
    end else begin
      // Follows the flag's next value, so set-beats-clear holds here too
      transferIrq <= ((transferDoneFlag & ~flagClear) | byteDone | modeFault)
                     & transferIrqEnable & globalIrqEnable;
    end
  end

  // Pin data and directions, registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sckOut  <= 1'b0;
      mosiOut <= 1'b0;
      misoOut <= 1'b0;
      pinOeN  <= '1;
    end else begin
      sckOut         <= (mst_d == MST_HIGH);
      mosiOut        <= shift_d[7];
      misoOut        <= shift_d[7];
      // Master pins follow software; fault turns them to inputs
      pinOeN.mosiOeN <= ~(isMaster & ~modeFault & pinDir.mosiDir);
      pinOeN.sckOeN  <= ~(isMaster & ~modeFault & pinDir.sckDir);
      // Slave drives MISO only when selected and configured
      pinOeN.misoOeN <= ~(slaveActive & pinDir.misoDir);
      // Select output is a plain pin in master role
      pinOeN.selOeN  <= selIsInput;
    end
  end

endmodule // ssm_select_mode

/* File: pkg/ssm_pkg.sv */
/*
  Package for the select and role logic of the serial controller: timing
  counts, pin-direction carriers and the shift-sequencer state encoding.
  Assumes one 100 MHz core clock and a synchronous active-low reset.
*/
package ssm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;    // Core clock period
  localparam int unsigned DIV_SLOW      = 16;    // Serial clock divide with low rate bit
  localparam int unsigned DIV_FAST      = 4;     // Serial clock divide otherwise
  localparam int unsigned HALF_SLOW     = DIV_SLOW / 2;
  localparam int unsigned HALF_FAST     = DIV_FAST / 2;
  localparam int unsigned BITS_PER_BYTE = 8;     // Bits per transfer
  localparam logic [7:0]  DATA_RESET    = 8'h00; // Data and buffer reset value
  localparam logic [3:0]  CNT_RESET     = 4'h0;  // Divider and bit counter reset

  // Per-pin output enables, active low (low means the block drives the pin)
  typedef struct packed {
    logic misoOeN;
    logic mosiOeN;
    logic sckOeN;
    logic selOeN;
  } ssm_pin_oe_t;

  // Software direction wishes, high means the pin is an output
  typedef struct packed {
    logic misoDir;
    logic mosiDir;
    logic sckDir;
    logic selDir;
  } ssm_pin_dir_t;

  // Master shift sequencer
  typedef enum logic [1:0] {
    MST_IDLE  = 2'b00,
    MST_LOW   = 2'b01,
    MST_HIGH  = 2'b10
  } ssm_mst_state_t;

endpackage

/* File: verilog/ssm_rx_buffer.sv */
/*
  Receive buffer: one byte of storage loaded when a byte completes.
  Read data come out of a register. Assumes the loader pulses once per byte.
*/
`timescale 1ns/1ps
module ssm_rx_buffer
  import ssm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] loadData,
  output logic      [7:0] readData
);

  // Overwrites unread data: an unread byte is lost on the next load
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readData <= DATA_RESET;
    end else if (load) begin
      readData <= loadData;
    end
  end

endmodule // ssm_rx_buffer

/* File: bench/ssm_select_mode_chk.sv */
/* Checker for the select and role logic, bound to ssm_select_mode.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ssm_select_mode_chk
  import ssm_pkg::*;
(
  input wire logic   core_clk,
  input wire logic   rst_n,
  input wire logic   serialUnitEnable,
  input wire logic   rateSelectLow,
  input wire logic   transferIrqEnable,
  input wire logic   globalIrqEnable,
  input ssm_pin_dir_t pinDir,
  input wire logic   dataWrite,
  input wire logic   dataRead,
  input wire logic   irqAck,
  input wire logic   selIn,
  input wire logic   controllerRoleBit,
  input wire logic   transferDoneFlag,
  input wire logic   transferIrq,
  input wire logic   sckOut,
  input ssm_pin_oe_t pinOeN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Mode fault: demote, raise flag, release clock and data pins
  a_fault_demote: assert property (
    controllerRoleBit && serialUnitEnable && !pinDir.selDir && !selIn |=>
    !controllerRoleBit && transferDoneFlag && pinOeN.mosiOeN && pinOeN.sckOeN)
    else $error("mode fault not handled");
  // Slave role never drives the select pin
  a_slave_sel_in: assert property (
    serialUnitEnable && !controllerRoleBit |=> pinOeN.selOeN)
    else $error("select driven in slave role");
  // Deselected slave keeps clock and data pins released
  a_slave_quiet: assert property (
    !controllerRoleBit && !$past(controllerRoleBit) && selIn && $past(selIn)
    |-> pinOeN.misoOeN && pinOeN.mosiOeN && pinOeN.sckOeN)
    else $error("deselected slave drives a pin");
  // Selected slave drives its data out pin when asked to
  a_miso_on: assert property (
    !controllerRoleBit && serialUnitEnable && pinDir.misoDir && !selIn
    |=> !pinOeN.misoOeN) else $error("selected slave not driving");
  // Slow rate: high half is eight core cycles
  a_slow_high: assert property (
    $rose(sckOut) && rateSelectLow |=> sckOut [*7] ##1 !sckOut)
    else $error("slow serial clock half wrong");
  // Eight slow bits then the done flag
  a_done_time: assert property (
    dataWrite && controllerRoleBit && serialUnitEnable && rateSelectLow && !transferDoneFlag
    |-> ##[128:130] $rose(transferDoneFlag)) else $error("master byte time wrong");
  // Interrupt exactly when the flag stands with both enables
  a_irq_cause: assert property (
    transferIrq == (transferDoneFlag && $past(transferIrqEnable)
    && $past(globalIrqEnable))) else $error("interrupt without cause");
  // Flag stands until serviced or accessed
  a_flag_stands: assert property (
    transferDoneFlag && !irqAck && !dataRead && !dataWrite |=> transferDoneFlag)
    else $error("done flag dropped");
  c_fault: cover property (controllerRoleBit && !selIn && !pinDir.selDir);
  c_done: cover property ($rose(transferDoneFlag));
  c_irq: cover property ($rose(transferIrq));
endmodule // ssm_select_mode_chk

bind ssm_select_mode ssm_select_mode_chk u_chk (.core_clk, .rst_n, .serialUnitEnable,
  .rateSelectLow, .transferIrqEnable, .globalIrqEnable, .pinDir, .dataWrite, .dataRead,
  .irqAck, .selIn, .controllerRoleBit, .transferDoneFlag, .transferIrq, .sckOut, .pinOeN);

/* File: bench/ssm_far_master.sv */
/* Far-side master model: one frame per go pulse, MSB first.
   Assumes the core clock; pins change just after its rising edge. */
`timescale 1ns/1ps
module ssm_far_master (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] txByte,
  input  wire logic [3:0] nBits,
  input  wire logic       miso,
  output logic            selN,
  output logic            sck,
  output logic            mosi,
  output logic      [7:0] misoByte
);
  // Select idles high, clock stands low between frames
  initial begin
    selN = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    misoByte = 8'h00;
  end
  // Data change on the rising clock, so it stands across the sampled fall
  always @(posedge go) begin
    @(posedge core_clk);
    #1 selN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      repeat (4) @(posedge core_clk);
      #1 sck = 1'b1;
      mosi = txByte[7-i];
      misoByte = {misoByte[6:0], miso};
      repeat (4) @(posedge core_clk);
      #1 sck = 1'b0;
    end
    repeat (4) @(posedge core_clk);
    #1 selN = 1'b1;
    mosi = ~mosi;   // Stale data is not left on the wire
  end
endmodule // ssm_far_master

/* File: bench/tb_spi_select_mode_logic.sv */
/* Testbench: master send, mode fault with receive, select abort.
   Assumes the far master model and the bound checker. */
`timescale 1ns/1ps
module tb_spi_select_mode_logic
  import ssm_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, serialUnitEnable = 1'b0, roleSetMaster = 1'b0;
  logic roleClear = 1'b0, rateSelectLow = 1'b0, transferIrqEnable = 1'b0;
  logic globalIrqEnable = 1'b0, dataWrite = 1'b0, dataRead = 1'b0, statusRead = 1'b0;
  logic irqAck = 1'b0, misoIn = 1'b1, go = 1'b0;
  logic [7:0] dataWriteValue = 8'h00, txByte = 8'h00, serialDataRead;
  logic [3:0] nBits = 4'h8;
  ssm_pin_dir_t pinDir = 4'h0;
  ssm_pin_oe_t pinOeN;
  logic selIn, sckIn, mosiIn, controllerRoleBit, transferDoneFlag, transferIrq;
  logic sckOut, mosiOut, misoOut;
  logic [7:0] misoByte;
  int fail_count = 0, num_checks = 0;
  always #5 core_clk = ~core_clk;
  ssm_select_mode DUT (.core_clk, .rst_n, .serialUnitEnable, .roleSetMaster, .roleClear,
    .rateSelectLow, .transferIrqEnable, .globalIrqEnable, .pinDir, .dataWrite,
    .dataWriteValue, .dataRead, .statusRead, .irqAck, .selIn, .sckIn, .mosiIn, .misoIn,
    .controllerRoleBit, .transferDoneFlag, .transferIrq, .serialDataRead, .sckOut,
    .mosiOut, .misoOut, .pinOeN);
  // A released data-out pin reads inverted, so a missing drive shows up
  ssm_far_master farEnd (.core_clk, .go, .txByte, .nBits,
    .miso(pinOeN.misoOeN ? ~misoOut : misoOut), .selN(selIn), .sck(sckIn),
    .mosi(mosiIn), .misoByte);
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkOe(ssm_pin_oe_t got, logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Inputs always change 1 ns after an edge
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // Bounded wait for the done flag
  task automatic waitFlag();
    int n;
    n = 0;
    while (transferDoneFlag !== 1'b1) begin
      tick(1);
      if (++n > 300) begin
        fail_count++;
        conclude();
      end
    end
  endtask
  // Master byte at the slow rate, then the read-sequence clear
  task automatic t_master();
    logic [7:0] got;
    logic last;
    got = 8'h00;
    last = 1'b0;
    pinDir = 4'b0110;
    rateSelectLow = 1'b1;
    pulse(roleSetMaster);
    dataWriteValue = 8'ha5;
    pulse(dataWrite);
    repeat (135) begin
      if (sckOut === 1'b1 && last === 1'b0) got = {got[6:0], mosiOut};
      last = sckOut;
      tick(1);
    end
    chk(got, 8'ha5);
    chkBit(transferDoneFlag, 1'b1);
    chk(serialDataRead, 8'hff);
    pulse(statusRead);
    pulse(dataRead);
    chkBit(transferDoneFlag, 1'b0);
  endtask
  // Another master selects us while master with input select
  task automatic t_fault();
    transferIrqEnable = 1'b1;
    globalIrqEnable = 1'b1;
    pulse(roleSetMaster);
    txByte = 8'hc3;
    pulse(go);
    tick(3);
    chkBit(controllerRoleBit, 1'b0);
    chkOe(pinOeN, 4'hf);
    chkBit(transferDoneFlag, 1'b1);
    chkBit(transferIrq, 1'b1);
    pulse(irqAck);
    chkBit(transferDoneFlag, 1'b0);
    waitFlag();
    chk(serialDataRead, 8'hc3);
    pulse(irqAck);
    tick(12);
    // Software brings master role back, select as a plain output
    pinDir = 4'b0111;
    pulse(roleSetMaster);
    tick(1);
    chkBit(controllerRoleBit, 1'b1);
    chkOe(pinOeN, 4'h8);
    pulse(roleClear);
    tick(1);
    chkBit(controllerRoleBit, 1'b0);
    chkOe(pinOeN, 4'hf);
  endtask
  // Select rises after three bits; next byte must still align
  task automatic t_abort();
    pinDir = 4'b1000;
    tick(1);
    chkOe(pinOeN, 4'hf);
    txByte = 8'hff;
    nBits = 4'h3;
    pulse(go);
    tick(40);
    dataWriteValue = 8'h5a;
    pulse(dataWrite);
    txByte = 8'h3c;
    nBits = 4'h8;
    pulse(go);
    waitFlag();
    chk(serialDataRead, 8'h3c);
    chkOe(pinOeN, 4'h7);
    chk(misoByte, 8'h5a);
  endtask
  initial begin
    tick(12);
    rst_n = 1'b1;
    chkOe(pinOeN, 4'hf);
    serialUnitEnable = 1'b1;
    tick(1);
    t_master();
    t_fault();
    t_abort();
    conclude();
  end
endmodule // tb_spi_select_mode_logic
